/* include/csl_pkg.sv */
// constants for the serial configuration loader
package csl_pkg;

  // ==========================================
  // configuration word geometry
  localparam int CSL_WORD_BITS = 132;
  localparam int CSL_SYNC_STAGES = 3;

  // ==========================================
  // control bit positions
  localparam int CSL_BIT_OUT1_EN = 110;
  localparam int CSL_BIT_OUT2_EN = 111;
  localparam int CSL_BIT_PLL_RUN = 112;
  localparam int CSL_BIT_OUT3_EN = 129;

  // ==========================================
  // power-up word: outputs on, pll running, divider fields left zero here;
  // a real part ships its own divider pattern, replace as needed
  localparam logic [CSL_WORD_BITS-1:0] CSL_DEFAULT_WORD =
    (132'h1 << CSL_BIT_OUT1_EN) |
    (132'h1 << CSL_BIT_OUT2_EN) |
    (132'h1 << CSL_BIT_PLL_RUN) |
    (132'h1 << CSL_BIT_OUT3_EN);

  // ==========================================
  // values after reset of the pin filters (idle levels set by the pulls)
  localparam logic CSL_SCLK_IDLE = 1'b1;
  localparam logic CSL_LOAD_IDLE = 1'b0;
  localparam logic CSL_DATA_IDLE = 1'b1;
  localparam logic CSL_PDN_IDLE = 1'b1;

endpackage

/* verilog/csl_loader.sv */
// serial configuration loader for a programmable clock synthesizer
`timescale 1ns/100ps
module csl_loader
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // serial programming pins
  input wire logic shift_clock_i,
  input wire logic serial_data_i,
  input wire logic load_strobe_i,
  // power-down pin, low powers down
  input wire logic power_down_n_i,
  // active configuration towards the synthesizer core
  output logic [csl_pkg::CSL_WORD_BITS-1:0] control_word_o,
  output logic first_output_enable_o,
  output logic second_output_enable_o,
  output logic third_output_enable_o,
  output logic synth_run_o
);
  import csl_pkg::*;

  // ==========================================
  // pin synchronisers: three stages; for sclk, load and pdn stage 2 and 3 must agree
  logic [CSL_SYNC_STAGES-1:0] sclk_sync;
  logic [CSL_SYNC_STAGES-1:0] data_sync;
  logic [CSL_SYNC_STAGES-1:0] load_sync;
  logic [CSL_SYNC_STAGES-1:0] pdn_sync;
  logic sclk_lvl;
  logic load_lvl;
  logic pdn_lvl;
  logic sclk_rise;
  logic [CSL_WORD_BITS-1:0] shift_reg;

  function automatic logic agreed(input logic [CSL_SYNC_STAGES-1:0] s, input logic held);
    agreed = (s[1] == s[2]) ? s[2] : held;
  endfunction

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sclk_sync <= {CSL_SYNC_STAGES{CSL_SCLK_IDLE}};
      data_sync <= {CSL_SYNC_STAGES{CSL_DATA_IDLE}};
      load_sync <= {CSL_SYNC_STAGES{CSL_LOAD_IDLE}};
      pdn_sync <= {CSL_SYNC_STAGES{CSL_PDN_IDLE}};
    end
    else
    begin
      sclk_sync <= {sclk_sync[1:0], shift_clock_i};
      data_sync <= {data_sync[1:0], serial_data_i};
      load_sync <= {load_sync[1:0], load_strobe_i};
      pdn_sync <= {pdn_sync[1:0], power_down_n_i};
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sclk_lvl <= CSL_SCLK_IDLE;
      load_lvl <= CSL_LOAD_IDLE;
      pdn_lvl <= CSL_PDN_IDLE;
    end
    else
    begin
      sclk_lvl <= agreed(sclk_sync, sclk_lvl);
      load_lvl <= agreed(load_sync, load_lvl);
      pdn_lvl <= agreed(pdn_sync, pdn_lvl);
    end
  end

  // filtered level is low, stages 2 and 3 agree high: one edge
  assign sclk_rise = !sclk_lvl && sclk_sync[1] && sclk_sync[2];

  // ==========================================
  // shift register; data stage 3 lines up with the clock decision
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      shift_reg <= '0;
    else if (sclk_rise)
      shift_reg <= {shift_reg[CSL_WORD_BITS-2:0], data_sync[2]};
  end

  // ==========================================
  // active register; the whole word moves in one cycle, so divider
  // pairs never sit half old, half new (output-path glitches are the core's)
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      control_word_o <= CSL_DEFAULT_WORD;
    else if (load_lvl)
      control_word_o <= shift_reg;
  end

  // enables and run state are separate flops; the enables load alongside the word, run is updated every cycle
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      first_output_enable_o <= CSL_DEFAULT_WORD[CSL_BIT_OUT1_EN];
      second_output_enable_o <= CSL_DEFAULT_WORD[CSL_BIT_OUT2_EN];
      third_output_enable_o <= CSL_DEFAULT_WORD[CSL_BIT_OUT3_EN];
    end
    else if (load_lvl)
    begin
      first_output_enable_o <= shift_reg[CSL_BIT_OUT1_EN];
      second_output_enable_o <= shift_reg[CSL_BIT_OUT2_EN];
      third_output_enable_o <= shift_reg[CSL_BIT_OUT3_EN];
    end
  end

  // run needs both the pin and bit 112; loading never looks at either
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      synth_run_o <= CSL_DEFAULT_WORD[CSL_BIT_PLL_RUN];
    else if (load_lvl)
      synth_run_o <= shift_reg[CSL_BIT_PLL_RUN] && pdn_lvl;
    else
      synth_run_o <= control_word_o[CSL_BIT_PLL_RUN] && pdn_lvl;
  end

  // ==========================================
  // checks
  shift_capture_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sclk_rise |=> shift_reg[0] == $past(data_sync[2]))
    else $error("serial bit not captured on shift edge");

  shift_order_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sclk_rise |=> shift_reg[CSL_WORD_BITS-1:1] == $past(shift_reg[CSL_WORD_BITS-2:0]))
    else $error("shift register did not move toward msb");

  shift_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !sclk_rise |=> $stable(shift_reg))
    else $error("shift register moved without a shift edge");

  word_load_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    load_lvl |=> control_word_o == $past(shift_reg))
    else $error("active word not loaded while strobe high");

  idle_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !load_lvl |=> $stable(control_word_o))
    else $error("active word changed with strobe low");

  pdown_load_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (load_lvl && !synth_run_o) |=> control_word_o == $past(shift_reg))
    else $error("load refused during power-down");

  enable_map_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    load_lvl |=> (first_output_enable_o == $past(shift_reg[CSL_BIT_OUT1_EN]))
      && (second_output_enable_o == $past(shift_reg[CSL_BIT_OUT2_EN]))
      && (third_output_enable_o == $past(shift_reg[CSL_BIT_OUT3_EN])))
    else $error("output enables do not follow loaded bits");

  run_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !load_lvl ##1 !load_lvl |-> synth_run_o == ($past(control_word_o[CSL_BIT_PLL_RUN]) && $past(pdn_lvl)))
    else $error("run state does not follow bit 112 and pin");

  default_word_a: assert property (@(posedge clock_i)
    !rst_n_i |=> control_word_o == CSL_DEFAULT_WORD && synth_run_o)
    else $error("reset did not restore default word");

  single_edge_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sclk_rise |=> !sclk_rise)
    else $error("one shift clock edge counted twice");

  // a half-agreed pin must not move the filtered level, or one slow edge counts twice
  sclk_filter_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (sclk_sync[1] != sclk_sync[2]) |=> $stable(sclk_lvl))
    else $error("shift clock level moved before stages agreed");

  load_filter_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (load_sync[1] != load_sync[2]) |=> $stable(load_lvl))
    else $error("load level moved before stages agreed");

  pin_idle_a: assert property (@(posedge clock_i)
    !rst_n_i |=> sclk_lvl && !load_lvl)
    else $error("pin levels not idle after reset");

  enable_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !load_lvl |=> $stable({first_output_enable_o, second_output_enable_o, third_output_enable_o}))
    else $error("output enables changed with strobe low");

  run_pin_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !pdn_lvl |=> !synth_run_o)
    else $error("run state high while power pin low");

  // ==========================================
  // scenarios worth seeing
  load_seen_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    sclk_rise ##[1:40] load_lvl);

  pdown_load_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    !synth_run_o && load_lvl);

  edges_back_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    sclk_rise ##[2:8] sclk_rise ##[2:8] sclk_rise);

  run_off_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(synth_run_o));

  run_back_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(synth_run_o));

endmodule

/* dv/csl_host_model.sv */
// host model driving the serial programming pins
`timescale 1ns/100ps
module csl_host_model
(
  // clock
  input wire logic clock_i,
  // serial programming pins
  output logic shift_clock_o,
  output logic serial_data_o,
  output logic load_strobe_o
);
  import csl_pkg::*;
  initial
  begin
    shift_clock_o = 1'b0;
    serial_data_o = CSL_DATA_IDLE;
    load_strobe_o = 1'b0;
  end
  // each level held 4 cycles so the pin filters never miss a bit
  task automatic send_bits(input logic [CSL_WORD_BITS-1:0] w);
    for (int i = CSL_WORD_BITS - 1; i >= 0; i--)
    begin
      serial_data_o <= w[i];
      shift_clock_o <= 1'b0;
      repeat (4) @(posedge clock_i);
      shift_clock_o <= 1'b1;
      repeat (4) @(posedge clock_i);
    end
    shift_clock_o <= 1'b0;
    serial_data_o <= CSL_DATA_IDLE;
    repeat (4) @(posedge clock_i);
  endtask
  // strobe only after a whole word, sclk kept low meanwhile
  task automatic strobe();
    load_strobe_o <= 1'b1;
    repeat (6) @(posedge clock_i);
    load_strobe_o <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask
endmodule

/* dv/csl_loader_tb_top.sv */
// testbench for the serial configuration loader
`timescale 1ns/100ps
module csl_loader_tb_top;
  import csl_pkg::*;
  // test pattern only; a real host keeps the divider fields inside the core's limits
  localparam logic [CSL_WORD_BITS-1:0] WORD_B = 132'ha_0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic power_down_n_i = 1'b1;
  logic sclk, sdata, load, en1, en2, en3, run;
  logic [CSL_WORD_BITS-1:0] word_o;
  int err_count = 0;
  int comparisons = 0;
  initial
  begin
    forever #5 clock_i = ~clock_i;
  end
  csl_host_model u_host (.clock_i(clock_i), .shift_clock_o(sclk), .serial_data_o(sdata), .load_strobe_o(load));
  csl_loader u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .shift_clock_i(sclk), .serial_data_i(sdata),
    .load_strobe_i(load), .power_down_n_i(power_down_n_i), .control_word_o(word_o),
    .first_output_enable_o(en1), .second_output_enable_o(en2), .third_output_enable_o(en3), .synth_run_o(run));
  task automatic compare(input string what, input logic [CSL_WORD_BITS-1:0] exp, input logic [CSL_WORD_BITS-1:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  // look at the settled outputs mid-cycle, then hand back on a rising edge
  task automatic check_all(input logic [CSL_WORD_BITS-1:0] w, input logic pin);
    @(negedge clock_i);
    compare("control word", w, word_o);
    compare("first enable", CSL_WORD_BITS'(w[CSL_BIT_OUT1_EN]), CSL_WORD_BITS'(en1));
    compare("second enable", CSL_WORD_BITS'(w[CSL_BIT_OUT2_EN]), CSL_WORD_BITS'(en2));
    compare("third enable", CSL_WORD_BITS'(w[CSL_BIT_OUT3_EN]), CSL_WORD_BITS'(en3));
    compare("run state", CSL_WORD_BITS'(w[CSL_BIT_PLL_RUN] & pin), CSL_WORD_BITS'(run));
    @(posedge clock_i);
  endtask
  task automatic shift_then_load();
    u_host.send_bits(~WORD_B);
    check_all(CSL_DEFAULT_WORD, 1'b1);
    u_host.send_bits(WORD_B);
    u_host.strobe();
    check_all(WORD_B, 1'b1);
  endtask
  // bit 112 low must still let the next word in
  task automatic bit_power_down();
    u_host.send_bits(~WORD_B);
    u_host.strobe();
    check_all(~WORD_B, 1'b1);
    u_host.send_bits(WORD_B);
    u_host.strobe();
    check_all(WORD_B, 1'b1);
  endtask
  task automatic pin_power_down();
    power_down_n_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    check_all(WORD_B, 1'b0);
    u_host.send_bits(~WORD_B);
    u_host.strobe();
    check_all(~WORD_B, 1'b0);
    u_host.send_bits(WORD_B);
    u_host.strobe();
    check_all(WORD_B, 1'b0);
    power_down_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    check_all(WORD_B, 1'b1);
  endtask
  task automatic apply_reset();
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check_all(CSL_DEFAULT_WORD, 1'b1);
  endtask
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    apply_reset();
    shift_then_load();
    bit_power_down();
    pin_power_down();
    apply_reset();
    complete_run();
  end
  // about 6500 cycles expected, generous margin
  initial
  begin
    repeat (30000) @(posedge clock_i);
    err_count++;
    complete_run();
  end
endmodule
